// [hdl/tpcpwm_pkg.sv]
package tpcpwm_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int CNT_W = 16;
    localparam int NPH = 3;
    localparam int IRQ_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_DEADTIME = 8'h08;
    localparam logic [7:0] ADDR_DUTY_A = 8'h0c;
    localparam logic [7:0] ADDR_DUTY_B = 8'h10;
    localparam logic [7:0] ADDR_DUTY_C = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_PROT_BIT = 2;
    localparam int STAT_EN_BIT = 0;
    localparam int STAT_MODE_BIT = 1;
    localparam int STAT_FAULT_BIT = 2;
    localparam int IRQ_PERIOD_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_PROT_BIT = 2;

    // ----------------------------------------
    // reset values and counter constants
    // ----------------------------------------
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'h03e8;
    localparam logic [CNT_W-1:0] DEADTIME_RST = 16'h0010;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic {
        TPCPWM_MODE_CENTER,
        TPCPWM_MODE_EDGE
    } tpcpwm_mode_t;

    typedef struct packed {
        logic hi;
        logic lo;
    } tpcpwm_pair_t;

    typedef struct packed {
        logic en;
        tpcpwm_mode_t mode;
    } tpcpwm_cfg_t;

endpackage

// [hdl/tpcpwm_timebase.sv]
`timescale 1ns/1ps
module tpcpwm_timebase #(
    parameter int CNT_W = tpcpwm_pkg::CNT_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_run,
    input wire tpcpwm_pkg::tpcpwm_mode_t i_mode,
    input wire logic [CNT_W-1:0] i_period,
    output logic [CNT_W-1:0] o_count,
    output logic o_reload
);

    // ----------------------------------------
    // shared carrier counter
    // ----------------------------------------
    logic up_r;

    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v, input logic up);
        step = up ? v + CNT_W'(1) : v - CNT_W'(1);
    endfunction

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_run) begin
            o_count <= '0;
            up_r <= 1'b1;
            o_reload <= 1'b0;
        end else begin
            o_reload <= 1'b0;
            if (i_period == '0) begin
                o_count <= '0;
                up_r <= 1'b1;
            end else if (i_mode == tpcpwm_pkg::TPCPWM_MODE_EDGE) begin
                // sawtooth 0..period
                if (o_count >= i_period) begin
                    o_count <= '0;
                    o_reload <= 1'b1;
                end else begin
                    o_count <= step(o_count, 1'b1);
                end
            end else if (up_r) begin
                // triangle rising half
                if (o_count >= i_period) begin
                    up_r <= 1'b0;
                    o_count <= step(o_count, 1'b0);
                end else begin
                    o_count <= step(o_count, 1'b1);
                end
            end else begin
                // triangle falling half
                if (o_count == '0) begin
                    up_r <= 1'b1;
                    o_count <= step(o_count, 1'b1);
                    o_reload <= 1'b1;
                end else begin
                    o_count <= step(o_count, 1'b0);
                end
            end
        end
    end

endmodule

// [hdl/tpcpwm_top.sv]
// Contract
// RULE1 - six outputs form three complementary pairs, one upper and one lower per phase.
// RULE2 - all pairs share one carrier period, one dead time and one mode.
// RULE3 - one timebase makes the carrier that every phase compares against.
// RULE4 - each phase holds its own duty value that sets its switching points.
// RULE5 - a control part selects the mode and decides when interrupts are raised.
// RULE6 - on every transition both outputs of a pair stay off for the dead time.
// RULE7 - no minimum pulse is enforced, so a short pulse can vanish for a whole period.
// RULE8 - software should keep every pulse width at least three times the dead time.
// RULE9 - a software protection command turns all six outputs off together.
// RULE10 - the external fault input turns all outputs off and raises its interrupt.
// RULE11 - each phase switches where the triangular carrier crosses its reference; in edge mode the code compares against a sawtooth 0..period instead.
// RULE12 - after reset or a shutdown outputs stay off until software enables again.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module tpcpwm_top #(
    parameter int CNT_W = tpcpwm_pkg::CNT_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [tpcpwm_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [tpcpwm_pkg::DATA_W-1:0] i_pwdata,
    output logic [tpcpwm_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_ext_fault,
    output logic o_phase_a_out,
    output logic o_phase_a_out_compl,
    output logic o_phase_b_out,
    output logic o_phase_b_out_compl,
    output logic o_phase_c_out,
    output logic o_phase_c_out_compl,
    output logic o_irq
);

    localparam int NPH = tpcpwm_pkg::NPH;
    localparam int IRQ_W = tpcpwm_pkg::IRQ_W;
    localparam int DATA_W = tpcpwm_pkg::DATA_W;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
        widen = {{(DATA_W-CNT_W){1'b0}}, v};
    endfunction

    function automatic logic hit(input logic [tpcpwm_pkg::ADDR_W-1:0] a,
                                 input logic [tpcpwm_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic pready_r;
    logic pslverr_r;
    logic [DATA_W-1:0] prdata_r;
    logic wr_fire;
    logic rd_err;
    logic [DATA_W-1:0] rd_data;
    tpcpwm_pkg::tpcpwm_cfg_t cfg_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] dead_r;
    logic [CNT_W-1:0] duty_r [NPH];
    logic [CNT_W-1:0] duty_act_r [NPH];
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic irq_r;
    logic fault_meta_r;
    logic fault_sync_r;
    logic fault_prev_r;
    logic prot_cmd;
    logic shut;
    logic [CNT_W-1:0] count;
    logic reload;
    logic [NPH-1:0] raw_r;
    logic [NPH-1:0] raw_nxt;
    logic [CNT_W-1:0] dt_cnt_r [NPH];
    tpcpwm_pkg::tpcpwm_pair_t pair_r [NPH];

    // ----------------------------------------
    // apb slave handshake
    // ----------------------------------------
    // one wait state: pready rises in the second access cycle
    assign wr_fire = i_psel && i_penable && pready_r && i_pwrite;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= i_psel && i_penable && !pready_r;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (i_psel && i_penable && !pready_r) begin
            prdata_r <= i_pwrite ? '0 : rd_data;
            pslverr_r <= rd_err;
        end else begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (hit(i_paddr, tpcpwm_pkg::ADDR_CTRL)) begin
            rd_data[tpcpwm_pkg::CTRL_EN_BIT] = cfg_r.en;
            rd_data[tpcpwm_pkg::CTRL_MODE_BIT] = cfg_r.mode;
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_PERIOD)) begin
            rd_data = widen(period_r);
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_DEADTIME)) begin
            rd_data = widen(dead_r);
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_A)) begin
            rd_data = widen(duty_r[0]);
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_B)) begin
            rd_data = widen(duty_r[1]);
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_C)) begin
            rd_data = widen(duty_r[2]);
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_STATUS)) begin
            rd_data[tpcpwm_pkg::STAT_EN_BIT] = cfg_r.en;
            rd_data[tpcpwm_pkg::STAT_MODE_BIT] = cfg_r.mode;
            rd_data[tpcpwm_pkg::STAT_FAULT_BIT] = fault_sync_r;
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_IRQ_STAT)) begin
            rd_data[IRQ_W-1:0] = irq_stat_r;
        end else if (hit(i_paddr, tpcpwm_pkg::ADDR_IRQ_MASK)) begin
            rd_data[IRQ_W-1:0] = irq_mask_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ----------------------------------------
    // fault input synchroniser
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            fault_meta_r <= 1'b0;
            fault_sync_r <= 1'b0;
            fault_prev_r <= 1'b0;
        end else begin
            fault_meta_r <= i_ext_fault;
            fault_sync_r <= fault_meta_r;
            fault_prev_r <= fault_sync_r;
        end
    end

    // ----------------------------------------
    // protection
    // ----------------------------------------
    assign prot_cmd = wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_CTRL) &&
                      i_pwdata[tpcpwm_pkg::CTRL_PROT_BIT]; // see RULE9
    assign shut = prot_cmd || fault_sync_r; // see RULE10

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cfg_r.en <= 1'b0;
        end else if (shut) begin
            cfg_r.en <= 1'b0; // see RULE12
        end else if (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_CTRL)) begin
            cfg_r.en <= i_pwdata[tpcpwm_pkg::CTRL_EN_BIT]; // see RULE12
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cfg_r.mode <= tpcpwm_pkg::TPCPWM_MODE_CENTER;
        end else if (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_CTRL)) begin
            // one mode for all pairs
            cfg_r.mode <= tpcpwm_pkg::tpcpwm_mode_t'(
                i_pwdata[tpcpwm_pkg::CTRL_MODE_BIT]); // see RULE5, see RULE2
        end
    end

    // ----------------------------------------
    // period and dead time
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            period_r <= tpcpwm_pkg::PERIOD_RST;
        end else if (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_PERIOD)) begin
            period_r <= i_pwdata[CNT_W-1:0]; // see RULE2
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dead_r <= tpcpwm_pkg::DEADTIME_RST;
        end else if (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_DEADTIME)) begin
            dead_r <= i_pwdata[CNT_W-1:0]; // see RULE2
        end
    end

    // ----------------------------------------
    // duty registers
    // ----------------------------------------
    // shadow copies reach the compare at the carrier reload, or on every cycle while disabled
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int p = 0; p < NPH; p++) begin
                duty_r[p] <= tpcpwm_pkg::DUTY_RST;
            end
        end else if (wr_fire) begin
            if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_A)) begin
                duty_r[0] <= i_pwdata[CNT_W-1:0]; // see RULE4
            end
            if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_B)) begin
                duty_r[1] <= i_pwdata[CNT_W-1:0]; // see RULE4
            end
            if (hit(i_paddr, tpcpwm_pkg::ADDR_DUTY_C)) begin
                duty_r[2] <= i_pwdata[CNT_W-1:0]; // see RULE4
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int p = 0; p < NPH; p++) begin
                duty_act_r[p] <= tpcpwm_pkg::DUTY_RST;
            end
        end else if (reload || !cfg_r.en) begin
            for (int p = 0; p < NPH; p++) begin
                duty_act_r[p] <= duty_r[p]; // see RULE4
            end
        end
    end

    // ----------------------------------------
    // shared timebase
    // ----------------------------------------
    tpcpwm_timebase #(
        .CNT_W(CNT_W)
    ) u_timebase (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_run(cfg_r.en),
        .i_mode(cfg_r.mode),
        .i_period(period_r),
        .o_count(count),
        .o_reload(reload)
    ); // see RULE3

    // ----------------------------------------
    // phase compare and dead time
    // ----------------------------------------
    always_comb begin
        for (int p = 0; p < NPH; p++) begin
            raw_nxt[p] = (count < duty_act_r[p]); // see RULE11
        end
    end

    // a change of demand restarts the gap; no minimum pulse is kept
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !cfg_r.en) begin
            raw_r <= '0;
            for (int p = 0; p < NPH; p++) begin
                dt_cnt_r[p] <= dead_r; // see RULE6
            end
        end else begin
            raw_r <= raw_nxt;
            for (int p = 0; p < NPH; p++) begin
                if (raw_nxt[p] != raw_r[p]) begin
                    dt_cnt_r[p] <= dead_r; // see RULE6, see RULE7
                end else if (dt_cnt_r[p] != tpcpwm_pkg::CNT_ZERO) begin
                    dt_cnt_r[p] <= dt_cnt_r[p] - tpcpwm_pkg::CNT_ONE;
                end
            end
        end
    end

    // ----------------------------------------
    // output pairs
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int p = 0; p < NPH; p++) begin
                pair_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPH; p++) begin
                if (shut || !cfg_r.en) begin
                    pair_r[p] <= '0; // see RULE9, see RULE10, see RULE12
                end else if (dt_cnt_r[p] != tpcpwm_pkg::CNT_ZERO) begin
                    pair_r[p] <= '0; // see RULE6
                end else begin
                    pair_r[p].hi <= raw_r[p]; // see RULE1
                    pair_r[p].lo <= !raw_r[p]; // see RULE1
                end
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always_comb begin
        irq_event = '0;
        irq_event[tpcpwm_pkg::IRQ_PERIOD_BIT] = reload; // see RULE5
        irq_event[tpcpwm_pkg::IRQ_FAULT_BIT] = fault_sync_r && !fault_prev_r; // see RULE10
        irq_event[tpcpwm_pkg::IRQ_PROT_BIT] = prot_cmd; // see RULE9
    end

    assign irq_clr = (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_IRQ_STAT)) ?
                     i_pwdata[IRQ_W-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_stat_r <= tpcpwm_pkg::IRQ_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_event; // see RULE5
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_mask_r <= tpcpwm_pkg::IRQ_RST;
        end else if (wr_fire && hit(i_paddr, tpcpwm_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_r <= i_pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r); // see RULE5
        end
    end

    // ----------------------------------------
    // port drive
    // ----------------------------------------
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_irq = irq_r;
    assign o_phase_a_out = pair_r[0].hi;
    assign o_phase_a_out_compl = pair_r[0].lo;
    assign o_phase_b_out = pair_r[1].hi;
    assign o_phase_b_out_compl = pair_r[1].lo;
    assign o_phase_c_out = pair_r[2].hi;
    assign o_phase_c_out_compl = pair_r[2].lo;

endmodule

// [sim/tpcpwm_bench.sv]
`timescale 1ns/1ps
module tpcpwm_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int DT = 2;
    localparam int P = 20;
    logic i_clock;
    logic i_sys_rst;
    logic i_psel;
    logic i_penable;
    logic i_pwrite;
    logic i_trip;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic o_irq;
    logic fault;
    logic [5:0] outs;
    logic [15:0] overlap;
    logic [31:0] rd;
    logic er;
    int bad_count;
    int tests_run;
    int seed;

    tpcpwm_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_fault(fault),
        .o_phase_a_out(outs[5]), .o_phase_a_out_compl(outs[4]), .o_phase_b_out(outs[3]),
        .o_phase_b_out_compl(outs[2]), .o_phase_c_out(outs[1]),
        .o_phase_c_out_compl(outs[0]), .o_irq(o_irq));
    tpcpwm_gate_model gm (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_gates(outs),
        .i_trip(i_trip), .o_fault(fault), .o_overlap(overlap));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task tally_and_finish;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    function int hi_max(input int m, input int d);
        int w;
        w = m ? d : 2 * d - 1;
        return w > DT ? w : 0;
    endfunction

    function int hi_min(input int m, input int d);
        int w;
        w = m ? d : 2 * d - 1;
        return w > DT + 3 ? w - DT - 3 : 0;
    endfunction

    task run_mode(input int m, input int k);
        int win;
        int d[3];
        int h[3];
        win = m ? P + 1 : 2 * P;
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h0);
        for (int p = 0; p < 3; p++) begin
            d[p] = (k == 1 && p == 0) ? 1 :
                   3 * DT + int'($unsigned($random(seed)) % 12);
            h[p] = 0;
            apb(1'b1, tpcpwm_pkg::ADDR_DUTY_A + 8'(4 * p), 32'(d[p]));
        end
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'(1 + 2 * m));
        repeat (3 * win) @(posedge i_clock);
        for (int i = 0; i < win; i++) begin
            @(posedge i_clock);
            h[0] += int'(outs[5]);
            h[1] += int'(outs[3]);
            h[2] += int'(outs[1]);
        end
        for (int p = 0; p < 3; p++) begin
            chk(32'(h[p] >= hi_min(m, d[p]) && h[p] <= hi_max(m, d[p])), 32'h1);
        end
        chk(32'(overlap), 32'h0);
        apb(1'b0, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h7);
        $display("run mode %0d case %0d done", m, k);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [7:0] ad[9];
        logic [31:0] ex[9];
        logic [7:0] a;
        logic [31:0] v;
        ad = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        ex = '{32'h0, 32'(tpcpwm_pkg::PERIOD_RST), 32'(tpcpwm_pkg::DEADTIME_RST),
               32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        seed = 32'h1459;
        {bad_count, tests_run} = '0;
        {i_psel, i_penable, i_pwrite, i_trip, i_paddr, i_pwdata} = '0;
        i_sys_rst = 1'b1;
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        chk(32'(outs), 32'h0);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, ad[i], 32'h0);
            chk(rd, ex[i]);
        end
        apb(1'b1, 8'h24, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, er} + rd, 32'h1);
        for (int i = 0; i < 20; i++) begin
            a = 8'h04 + 8'(4 * (i % 5));
            v = $random(seed);
            apb(1'b1, a, v);
            apb(1'b0, a, 32'h0);
            chk(rd, v & 32'h0000_ffff);
        end
        $display("register test done");
        apb(1'b1, tpcpwm_pkg::ADDR_PERIOD, 32'(P));
        apb(1'b1, tpcpwm_pkg::ADDR_DEADTIME, 32'(DT));
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 2; k++) begin
                run_mode(m, k);
            end
        end
        apb(1'b1, tpcpwm_pkg::ADDR_IRQ_MASK, 32'h4);
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h4);
        repeat (2) @(posedge i_clock);
        chk(32'(outs), 32'h0);
        chk(32'(o_irq), 32'h1);
        apb(1'b1, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h4);
        repeat (2) @(posedge i_clock);
        chk(32'(o_irq), 32'h0);
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h5);
        apb(1'b0, tpcpwm_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        apb(1'b0, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h4, 32'h4);
        apb(1'b1, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h4);
        $display("protect test done");
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h1);
        i_trip <= 1'b1;
        repeat (5) @(posedge i_clock);
        chk(32'(outs), 32'h0);
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, tpcpwm_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h4);
        apb(1'b0, tpcpwm_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2);
        chk(32'(o_irq), 32'h0);
        i_trip <= 1'b0;
        repeat (5) @(posedge i_clock);
        apb(1'b1, tpcpwm_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, tpcpwm_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h1);
        $display("fault test done");
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        tally_and_finish;
    end
endmodule

// [sim/tpcpwm_gate_model.sv]
`timescale 1ns/1ps
module tpcpwm_gate_model (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_gates,
    input wire logic i_trip,
    output logic o_fault,
    output logic [15:0] o_overlap
);
    // ----------------------------------------
    // power stage
    // ----------------------------------------
    // over-current trip drives the fault line back to the generator
    assign o_fault = i_trip;

    // counts cycles where a phase would short the dc bus
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_overlap <= 16'h0000;
        end else if ((i_gates[5] & i_gates[4]) | (i_gates[3] & i_gates[2])
                     | (i_gates[1] & i_gates[0])) begin
            o_overlap <= o_overlap + 16'h0001;
        end
    end
endmodule

// [sim/tpcpwm_monitor.sv]
`timescale 1ns/1ps
module tpcpwm_monitor #(
    parameter int CNT_W = tpcpwm_pkg::CNT_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [tpcpwm_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [tpcpwm_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [tpcpwm_pkg::DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_ext_fault,
    input wire logic o_phase_a_out,
    input wire logic o_phase_a_out_compl,
    input wire logic o_phase_b_out,
    input wire logic o_phase_b_out_compl,
    input wire logic o_phase_c_out,
    input wire logic o_phase_c_out_compl,
    input wire logic o_irq
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [5:0] outs;
    assign outs = {o_phase_a_out, o_phase_a_out_compl, o_phase_b_out, o_phase_b_out_compl,
                   o_phase_c_out, o_phase_c_out_compl};
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_no_shoot_thru: assert property (!(outs[5] && outs[4]) && !(outs[3] && outs[2])
        && !(outs[1] && outs[0])) else $error("pair on together");
    a_gap_after_hi: assert property ($fell(o_phase_a_out) |-> !o_phase_a_out_compl [*2])
        else $error("no dead time after upper off");
    a_gap_after_lo: assert property ($fell(o_phase_c_out_compl) |-> !o_phase_c_out [*2])
        else $error("no dead time after lower off");
    a_fault_kills_out: assert property (i_ext_fault [*3] |-> ##[1:3] outs == 6'h00)
        else $error("fault did not stop outputs");
    a_prot_kills_out: assert property (i_psel && i_penable && i_pwrite && o_pready
        && i_paddr == tpcpwm_pkg::ADDR_CTRL && i_pwdata[tpcpwm_pkg::CTRL_PROT_BIT]
        |-> ##[1:2] outs == 6'h00) else $error("protect did not stop outputs");
    a_reset_off: assert property (disable iff (1'b0) i_sys_rst |=> outs == 6'h00)
        else $error("outputs on after reset");
    a_apb_answer: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray read data");
endmodule

bind tpcpwm_top tpcpwm_monitor #(.CNT_W(CNT_W)) u_mon (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_fault(i_ext_fault), .o_phase_a_out(o_phase_a_out),
    .o_phase_a_out_compl(o_phase_a_out_compl), .o_phase_b_out(o_phase_b_out),
    .o_phase_b_out_compl(o_phase_b_out_compl), .o_phase_c_out(o_phase_c_out),
    .o_phase_c_out_compl(o_phase_c_out_compl), .o_irq(o_irq));
